// [rtl/pmucsr_pkg.sv]
// Package with register offsets, field positions and reset values of the PMU register bank.
package pmucsr_pkg;

  localparam int PMUCSR_NUM_REGS = 5;
  localparam int PMUCSR_ADDR_W = 8;
  localparam int PMUCSR_DATA_W = 8;
  localparam int PMUCSR_VCODE_W = 6;
  localparam int PMUCSR_THR_W = 4;
  localparam int PMUCSR_THERM_RSV_W = 6;

  localparam logic [7:0] PMUCSR_BATT_ADDR = 8'h00;
  localparam logic [7:0] PMUCSR_THERM_ADDR = 8'h01;

  // Entry 0 is regulator 1, entry 4 is regulator 5.
  localparam logic [4:0][7:0] PMUCSR_VPRI_ADDR = {8'h50, 8'h40, 8'h30, 8'h20, 8'h10};
  localparam logic [4:0][7:0] PMUCSR_VSEC_ADDR = {8'h00, 8'h41, 8'h31, 8'h21, 8'h00};
  localparam logic [4:0][7:0] PMUCSR_CTRL_ADDR = {8'h51, 8'h42, 8'h32, 8'h22, 8'h12};
  localparam logic [4:0] PMUCSR_HAS_SEC = 5'h0e;
  localparam int PMUCSR_DISCH_REG = 4;
  localparam int PMUCSR_NUM_PHASE = 4;

  // Bit positions in the two system registers.
  localparam int PMUCSR_UNMASK_BIT = 7;
  localparam int PMUCSR_FLAG_BIT = 6;
  localparam int PMUCSR_LIVE_BIT = 5;
  localparam int PMUCSR_BATT_RSV_BIT = 4;

  // Bit positions in a regulator control register.
  localparam int PMUCSR_ON_BIT = 7;
  localparam int PMUCSR_PHASE_BIT = 2;
  localparam int PMUCSR_FLTMSK_BIT = 1;
  localparam int PMUCSR_PG_BIT = 0;

  // Layout of the synchronised input vector.
  localparam int PMUCSR_SYNC_W = 13;
  localparam int PMUCSR_SI_BATT = 0;
  localparam int PMUCSR_SI_THERM = 1;
  localparam int PMUCSR_SI_VOUT_SELECT_PIN = 2;
  localparam int PMUCSR_SI_PG = 3;
  localparam int PMUCSR_SI_FLT = 8;

  // Reset values.
  localparam logic PMUCSR_RST_BIT = 1'b0;
  localparam logic [3:0] PMUCSR_RST_THR = 4'h0;
  localparam logic [5:0] PMUCSR_RST_VCODE = 6'h00;
  localparam logic [5:0] PMUCSR_RST_THERM_RSV = 6'h00;
  localparam logic [7:0] PMUCSR_RST_DATA = 8'h00;

endpackage

// [rtl/pmucsr_sync.sv]
// Two-flop synchroniser for a vector of asynchronous level inputs.
`timescale 1ns/10ps
module pmucsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule

// [rtl/pmucsr_bank.sv]
// Control and status register bank of the power-management unit.
//
// What this block does
// - 0x00 bit 7 is read/write low-battery interrupt unmask.
// - 0x00 bit 6 reads 1 once the low-battery interrupt was generated.
// - 0x00 bit 5 shows live battery-below-threshold comparator state.
// - 0x00 bits 3:0 hold read/write battery threshold code.
// - 0x01 bit 7 is read/write thermal interrupt unmask.
// - 0x01 bit 6 reads 1 once a thermal interrupt was generated.
// - Regulator 1 has one six-bit voltage code at 0x10.
// - Regulators 2 to 4 apply primary code while select pin is low.
// - Regulators 2 to 4 apply secondary code while select pin is high.
// - Control bit 7 enables or disables each regulator.
// - Control bit 2 of regulators 1 to 4 selects switching phase.
// - Control bit 1 unmasks that regulator's fault interrupt.
// - Control bit 0 reads live power-good status.
// - Regulator 5 has one six-bit code at 0x50, select pin ignored.
// - Regulator 5 control bit 2 enables output discharge in shutdown.
`timescale 1ns/10ps
module pmucsr_bank
  import pmucsr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [PMUCSR_ADDR_W-1:0] reg_addr_i,
  input wire logic [PMUCSR_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PMUCSR_DATA_W-1:0] reg_rdata_o,
  input wire logic batt_below_threshold_i,
  input wire logic thermal_event_i,
  input wire logic vout_select_pin_i,
  input wire logic [PMUCSR_NUM_REGS-1:0] power_good_i,
  input wire logic [PMUCSR_NUM_REGS-1:0] reg_fault_i,
  output logic [PMUCSR_THR_W-1:0] batt_threshold_code_o,
  output logic [PMUCSR_NUM_REGS*PMUCSR_VCODE_W-1:0] vout_code_o,
  output logic [PMUCSR_NUM_REGS-1:0] reg_enable_o,
  output logic [PMUCSR_NUM_PHASE-1:0] reg_phase_o,
  output logic shutdown_discharge_en_o,
  output logic irq_o
);

  // Synchronised copies of all pin inputs.
  logic [PMUCSR_SYNC_W-1:0] pins_async;
  logic [PMUCSR_SYNC_W-1:0] pins_sync;
  logic batt_below_threshold_live;
  logic thermal_live;
  logic vout_select_pin;
  logic [PMUCSR_NUM_REGS-1:0] pg_live;
  logic [PMUCSR_NUM_REGS-1:0] fault_live;

  // System register state.
  logic low_batt_irq_unmask_reg;
  logic low_batt_irq_flag_reg;
  logic batt_rsv_reg;
  logic [PMUCSR_THR_W-1:0] batt_threshold_code_reg;
  logic thermal_irq_unmask_reg;
  logic thermal_irq_flag_reg;
  logic [PMUCSR_THERM_RSV_W-1:0] therm_rsv_reg;
  logic batt_live_d_reg;
  logic thermal_live_d_reg;

  // Regulator register state, one entry per regulator.
  logic [PMUCSR_VCODE_W-1:0] vout_code_primary_reg [PMUCSR_NUM_REGS];
  logic [PMUCSR_VCODE_W-1:0] vout_code_secondary_reg [PMUCSR_NUM_REGS];
  logic [PMUCSR_NUM_REGS-1:0] on_reg;
  logic [PMUCSR_NUM_REGS-1:0] mode_bit_reg;
  logic [PMUCSR_NUM_REGS-1:0] fault_irq_unmask_reg;

  // Decoded strobes.
  logic wr_batt;
  logic wr_therm;
  logic batt_rise;
  logic therm_rise;
  logic [PMUCSR_DATA_W-1:0] rdata_next;
  logic irq_next;

  assign pins_async = {reg_fault_i, power_good_i, vout_select_pin_i,
                       thermal_event_i, batt_below_threshold_i};

  pmucsr_sync #(
    .WIDTH(PMUCSR_SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  assign batt_below_threshold_live = pins_sync[PMUCSR_SI_BATT];
  assign thermal_live = pins_sync[PMUCSR_SI_THERM];
  assign vout_select_pin = pins_sync[PMUCSR_SI_VOUT_SELECT_PIN];
  assign pg_live = pins_sync[PMUCSR_SI_PG +: PMUCSR_NUM_REGS];
  assign fault_live = pins_sync[PMUCSR_SI_FLT +: PMUCSR_NUM_REGS];

  assign wr_batt = reg_wr_i && (reg_addr_i == PMUCSR_BATT_ADDR);
  assign wr_therm = reg_wr_i && (reg_addr_i == PMUCSR_THERM_ADDR);
  assign batt_rise = batt_below_threshold_live && !batt_live_d_reg;
  assign therm_rise = thermal_live && !thermal_live_d_reg;

  // Edge history for the two event sources.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      batt_live_d_reg <= PMUCSR_RST_BIT;
      thermal_live_d_reg <= PMUCSR_RST_BIT;
    end else begin
      batt_live_d_reg <= batt_below_threshold_live;
      thermal_live_d_reg <= thermal_live;
    end
  end

  // Battery monitor register, writable fields.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_batt_irq_unmask_reg <= PMUCSR_RST_BIT;
      batt_rsv_reg <= PMUCSR_RST_BIT;
      batt_threshold_code_reg <= PMUCSR_RST_THR;
    end else if (wr_batt) begin
      low_batt_irq_unmask_reg <= reg_wdata_i[PMUCSR_UNMASK_BIT];
      batt_rsv_reg <= reg_wdata_i[PMUCSR_BATT_RSV_BIT];
      batt_threshold_code_reg <= reg_wdata_i[PMUCSR_THR_W-1:0];
    end
  end

  // The flag is acknowledged by any write to its register, since the bit
  // itself is read-only. A new event in the same cycle wins over the write.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_batt_irq_flag_reg <= PMUCSR_RST_BIT;
    end else if (batt_rise) begin
      low_batt_irq_flag_reg <= 1'b1;
    end else if (wr_batt) begin
      low_batt_irq_flag_reg <= 1'b0;
    end
  end

  // Thermal register, writable fields.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      thermal_irq_unmask_reg <= PMUCSR_RST_BIT;
      therm_rsv_reg <= PMUCSR_RST_THERM_RSV;
    end else if (wr_therm) begin
      thermal_irq_unmask_reg <= reg_wdata_i[PMUCSR_UNMASK_BIT];
      therm_rsv_reg <= reg_wdata_i[PMUCSR_THERM_RSV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      thermal_irq_flag_reg <= PMUCSR_RST_BIT;
    end else if (therm_rise) begin
      thermal_irq_flag_reg <= 1'b1;
    end else if (wr_therm) begin
      thermal_irq_flag_reg <= 1'b0;
    end
  end

  // Per-regulator storage and applied outputs.
  genvar gi;
  generate
    for (gi = 0; gi < PMUCSR_NUM_REGS; gi++) begin : g_reg
      logic wr_pri;
      logic wr_sec;
      logic wr_ctrl;
      logic use_sec;

      assign wr_pri = reg_wr_i && (reg_addr_i == PMUCSR_VPRI_ADDR[gi]);
      assign wr_sec = reg_wr_i && PMUCSR_HAS_SEC[gi] && (reg_addr_i == PMUCSR_VSEC_ADDR[gi]);
      assign wr_ctrl = reg_wr_i && (reg_addr_i == PMUCSR_CTRL_ADDR[gi]);
      // Pin low or no secondary selects the primary code.
      assign use_sec = PMUCSR_HAS_SEC[gi] && vout_select_pin;

      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          vout_code_primary_reg[gi] <= PMUCSR_RST_VCODE;
        end else if (wr_pri) begin
          vout_code_primary_reg[gi] <= reg_wdata_i[PMUCSR_VCODE_W-1:0];
        end
      end

      // Regulators without a secondary slot keep this at reset value.
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          vout_code_secondary_reg[gi] <= PMUCSR_RST_VCODE;
        end else if (wr_sec) begin
          vout_code_secondary_reg[gi] <= reg_wdata_i[PMUCSR_VCODE_W-1:0];
        end
      end

      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          on_reg[gi] <= PMUCSR_RST_BIT;
          mode_bit_reg[gi] <= PMUCSR_RST_BIT;
          fault_irq_unmask_reg[gi] <= PMUCSR_RST_BIT;
        end else if (wr_ctrl) begin
          on_reg[gi] <= reg_wdata_i[PMUCSR_ON_BIT];
          mode_bit_reg[gi] <= reg_wdata_i[PMUCSR_PHASE_BIT];
          fault_irq_unmask_reg[gi] <= reg_wdata_i[PMUCSR_FLTMSK_BIT];
        end
      end

      // The applied code follows the pin through a register, so a pin
      // change reaches the regulator three cycles later at most.
      always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          vout_code_o[gi*PMUCSR_VCODE_W +: PMUCSR_VCODE_W] <= PMUCSR_RST_VCODE;
        end else begin
          // Pin high picks the secondary code on regulators that have one.
          vout_code_o[gi*PMUCSR_VCODE_W +: PMUCSR_VCODE_W] <=
            use_sec ? vout_code_secondary_reg[gi] : vout_code_primary_reg[gi];
        end
      end
    end
  endgenerate

  // Control outputs toward the analog side.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_enable_o <= '0;
      reg_phase_o <= '0;
      shutdown_discharge_en_o <= PMUCSR_RST_BIT;
      batt_threshold_code_o <= PMUCSR_RST_THR;
    end else begin
      reg_enable_o <= on_reg;
      reg_phase_o <= mode_bit_reg[PMUCSR_NUM_PHASE-1:0];
      shutdown_discharge_en_o <= mode_bit_reg[PMUCSR_DISCH_REG];
      batt_threshold_code_o <= batt_threshold_code_reg;
    end
  end

  // Any unmasked status raises the interrupt.
  assign irq_next = (low_batt_irq_flag_reg && low_batt_irq_unmask_reg)
                 || (thermal_irq_flag_reg && thermal_irq_unmask_reg)
                 || |(fault_live & fault_irq_unmask_reg);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= PMUCSR_RST_BIT;
    end else begin
      irq_o <= irq_next;
    end
  end

  // Read multiplexer. Unmapped offsets and reserved read-only bits give zero.
  always_comb begin
    rdata_next = PMUCSR_RST_DATA;
    if (reg_addr_i == PMUCSR_BATT_ADDR) begin
      rdata_next[PMUCSR_UNMASK_BIT] = low_batt_irq_unmask_reg;
      rdata_next[PMUCSR_FLAG_BIT] = low_batt_irq_flag_reg;
      rdata_next[PMUCSR_LIVE_BIT] = batt_below_threshold_live;
      rdata_next[PMUCSR_BATT_RSV_BIT] = batt_rsv_reg;
      rdata_next[PMUCSR_THR_W-1:0] = batt_threshold_code_reg;
    end else if (reg_addr_i == PMUCSR_THERM_ADDR) begin
      rdata_next[PMUCSR_UNMASK_BIT] = thermal_irq_unmask_reg;
      rdata_next[PMUCSR_FLAG_BIT] = thermal_irq_flag_reg;
      rdata_next[PMUCSR_THERM_RSV_W-1:0] = therm_rsv_reg;
    end
    for (int i = 0; i < PMUCSR_NUM_REGS; i++) begin
      if (reg_addr_i == PMUCSR_VPRI_ADDR[i]) begin
        // Primary code readback for every regulator, the only code for the select-free ones.
        rdata_next[PMUCSR_VCODE_W-1:0] = vout_code_primary_reg[i];
      end
      if (PMUCSR_HAS_SEC[i] && (reg_addr_i == PMUCSR_VSEC_ADDR[i])) begin
        rdata_next[PMUCSR_VCODE_W-1:0] = vout_code_secondary_reg[i];
      end
      if (reg_addr_i == PMUCSR_CTRL_ADDR[i]) begin
        rdata_next[PMUCSR_ON_BIT] = on_reg[i];
        rdata_next[PMUCSR_PHASE_BIT] = mode_bit_reg[i];
        rdata_next[PMUCSR_FLTMSK_BIT] = fault_irq_unmask_reg[i];
        rdata_next[PMUCSR_PG_BIT] = pg_live[i];
      end
    end
  end

  // Reads only sample state and never clear a flag.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= PMUCSR_RST_DATA;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

endmodule

// [verif/pmucsr_bank_assertions.sv]
// Port-level checker for the register bank.
`timescale 1ns/10ps
module pmucsr_bank_assertions
  import pmucsr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [PMUCSR_ADDR_W-1:0] reg_addr_i,
  input wire logic [PMUCSR_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [PMUCSR_DATA_W-1:0] reg_rdata_o,
  input wire logic [PMUCSR_THR_W-1:0] batt_threshold_code_o,
  input wire logic [PMUCSR_NUM_REGS*PMUCSR_VCODE_W-1:0] vout_code_o,
  input wire logic [PMUCSR_NUM_REGS-1:0] reg_enable_o,
  input wire logic [PMUCSR_NUM_PHASE-1:0] reg_phase_o,
  input wire logic shutdown_discharge_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd_code;
    reg_rd_i && reg_addr_i inside {8'h10, 8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41, 8'h50};
  endsequence
  property p_thr;
    s_wr(8'h00) |-> ##2 batt_threshold_code_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold output wrong");
  property p_enable;
    s_wr(8'h22) |-> ##2 reg_enable_o[1] == $past(reg_wdata_i[7], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("enable output wrong");
  property p_phase;
    s_wr(8'h32) |-> ##2 reg_phase_o[2] == $past(reg_wdata_i[2], 2);
  endproperty
  a_phase: assert property (p_phase) else $error("phase output wrong");
  property p_disch;
    s_wr(8'h51) |-> ##2 shutdown_discharge_en_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_disch: assert property (p_disch) else $error("discharge output wrong");
  property p_code1;
    s_wr(8'h10) |-> ##2 vout_code_o[5:0] == $past(reg_wdata_i[5:0], 2);
  endproperty
  a_code1: assert property (p_code1) else $error("regulator 1 code wrong");
  property p_code5;
    s_wr(8'h50) |-> ##2 vout_code_o[29:24] == $past(reg_wdata_i[5:0], 2);
  endproperty
  a_code5: assert property (p_code5) else $error("regulator 5 code wrong");
  // Read data must not drift between reads, or a slow host sees a changed value.
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmapped;
    reg_rd_i && reg_addr_i inside {8'h02, 8'h11} |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_code_rsv;
    s_rd_code |=> reg_rdata_o[7:6] == 2'b00;
  endproperty
  a_code_rsv: assert property (p_code_rsv) else $error("reserved code bits set");
endmodule
bind pmucsr_bank pmucsr_bank_assertions i_pmucsr_bank_assertions (.ref_clk_i, .sys_rst_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .batt_threshold_code_o,
  .vout_code_o, .reg_enable_o, .reg_phase_o, .shutdown_discharge_en_o);

// [verif/pmucsr_host_model.sv]
// Host processor model that reads and writes the register port.
`timescale 1ns/10ps
module pmucsr_host_model
  import pmucsr_pkg::*;
(
  input wire logic ref_clk_i,
  output logic [PMUCSR_ADDR_W-1:0] reg_addr_o,
  output logic [PMUCSR_DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [PMUCSR_DATA_W-1:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // Idle lines flip so that a stale address or datum is never taken as live.
  task automatic release_bus();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    release_bus();
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge ref_clk_i);
    d = reg_rdata_i;
    release_bus();
  endtask
endmodule

// [verif/pmucsr_bank_test.sv]
// Self-checking testbench of the register bank.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module pmucsr_bank_test;
  import pmucsr_pkg::*;
  logic ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, batt_below_threshold_i;
  logic thermal_event_i, vout_select_pin_i, shutdown_discharge_en_o, irq_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [4:0] power_good_i, reg_fault_i, reg_enable_o;
  logic [3:0] batt_threshold_code_o, reg_phase_o;
  logic [29:0] vout_code_o;
  int fails = 0;
  int checks_done = 0;
  pmucsr_bank i_pmucsr_bank (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .batt_below_threshold_i, .thermal_event_i, .vout_select_pin_i,
    .power_good_i, .reg_fault_i, .batt_threshold_code_o, .vout_code_o, .reg_enable_o,
    .reg_phase_o, .shutdown_discharge_en_o, .irq_o);
  pmucsr_host_model i_pmucsr_host_model (.ref_clk_i, .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pmucsr_host_model.wr_reg(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_pmucsr_host_model.rd_reg(a, v);
    `CHK(v, e)
  endtask
  task automatic chk_codes(input logic vs);
    logic [5:0] e;
    for (int i = 0; i < 5; i++) begin
      e = (vs && PMUCSR_HAS_SEC[i]) ? 6'(8'h20 + i) : 6'(8'h01 + i);
      `CHK(vout_code_o[i*6 +: 6], e)
    end
  endtask
  task automatic t_reset_values();
    logic [7:0] m [15] = '{8'h00, 8'h01, 8'h10, 8'h12, 8'h20, 8'h21, 8'h22, 8'h30,
      8'h31, 8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51};
    foreach (m[i]) rd_chk(m[i], 8'h00);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      wr(PMUCSR_VPRI_ADDR[i], 8'(8'hc1 + i));
      rd_chk(PMUCSR_VPRI_ADDR[i], 8'(8'h01 + i));
      wr(PMUCSR_CTRL_ADDR[i], 8'hff);
      rd_chk(PMUCSR_CTRL_ADDR[i], 8'h86);
      if (PMUCSR_HAS_SEC[i]) begin
        wr(PMUCSR_VSEC_ADDR[i], 8'(8'he0 + i));
        rd_chk(PMUCSR_VSEC_ADDR[i], 8'(8'h20 + i));
      end
    end
    idle(3);
    `CHK(reg_enable_o, 5'h1f)
    `CHK(reg_phase_o, 4'hf)
    `CHK(shutdown_discharge_en_o, 1'b1)
    chk_codes(1'b0);
    vout_select_pin_i = 1'b1;
    idle(5);
    chk_codes(1'b1);
    wr(8'h22, 8'h02);
    wr(8'h51, 8'h80);
    idle(3);
    `CHK(reg_enable_o, 5'h1d)
    `CHK(reg_phase_o, 4'hd)
    `CHK(shutdown_discharge_en_o, 1'b0)
    vout_select_pin_i = 1'b0;
    idle(5);
    chk_codes(1'b0);
    wr(8'h11, 8'hff);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h02, 8'h00);
  endtask
  task automatic t_sys();
    wr(8'h00, 8'hff);
    rd_chk(8'h00, 8'h9f);
    `CHK(batt_threshold_code_o, 4'hf)
    wr(8'h01, 8'hff);
    rd_chk(8'h01, 8'hbf);
    batt_below_threshold_i = 1'b1;
    idle(5);
    rd_chk(8'h00, 8'hff);
    `CHK(irq_o, 1'b1)
    batt_below_threshold_i = 1'b0;
    idle(4);
    rd_chk(8'h00, 8'hdf);
    rd_chk(8'h00, 8'hdf);
    wr(8'h00, 8'h15);
    idle(3);
    rd_chk(8'h00, 8'h15);
    `CHK(irq_o, 1'b0)
    batt_below_threshold_i = 1'b1;
    idle(5);
    `CHK(irq_o, 1'b0)
    rd_chk(8'h00, 8'h75);
    batt_below_threshold_i = 1'b0;
    wr(8'h00, 8'h00);
    thermal_event_i = 1'b1;
    idle(5);
    thermal_event_i = 1'b0;
    idle(2);
    rd_chk(8'h01, 8'hff);
    `CHK(irq_o, 1'b1)
    wr(8'h01, 8'h00);
    idle(3);
    rd_chk(8'h01, 8'h00);
    `CHK(irq_o, 1'b0)
  endtask
  task automatic t_pg_fault();
    logic [7:0] ce [5] = '{8'h87, 8'h02, 8'h87, 8'h86, 8'h81};
    power_good_i = 5'h15;
    idle(4);
    for (int i = 0; i < 5; i++) rd_chk(PMUCSR_CTRL_ADDR[i], ce[i]);
    power_good_i = 5'h00;
    reg_fault_i = 5'h10;
    idle(5);
    `CHK(irq_o, 1'b0)
    reg_fault_i = 5'h04;
    idle(5);
    `CHK(irq_o, 1'b1)
    wr(8'h32, 8'h84);
    idle(3);
    `CHK(irq_o, 1'b0)
    reg_fault_i = 5'h00;
  endtask
  task automatic t_mid_reset();
    wr(8'h12, 8'h86);
    idle(3);
    `CHK(reg_enable_o[0], 1'b1)
    sys_rst_i = 1'b1;
    idle(2);
    `CHK(reg_enable_o, 5'h00)
    `CHK(reg_phase_o, 4'h0)
    `CHK(vout_code_o, 30'h0)
    `CHK(irq_o, 1'b0)
    sys_rst_i = 1'b0;
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h10, 8'h00);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    batt_below_threshold_i = 1'b0;
    thermal_event_i = 1'b0;
    vout_select_pin_i = 1'b0;
    power_good_i = 5'h00;
    reg_fault_i = 5'h00;
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset_values();
    t_regs();
    t_sys();
    t_pg_fault();
    t_mid_reset();
    results();
  end
  // The sequence needs well under a thousand cycles; this leaves ample slack.
  initial begin
    #50us;
    fails++;
    results();
  end
endmodule
